// ---- pin_mux_pkg.sv ----
// Constants, register map and carrier types for the debug/reset pin mux.
// Assumes a single 250 MHz system clock and a 32-bit AXI4-Lite slave port.
package pin_mux_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned SYS_CLK_HZ = 250_000_000;
  // Lockout after power-on, in milliseconds
  localparam int unsigned LOCKOUT_MS = 30;
  // Low-speed RC oscillator rate, arbitrary plain default
  localparam int unsigned OSC_HZ_DEFAULT = 32_000;
  // Oscillator ticks that make up the lockout
  localparam int unsigned LOCKOUT_TICKS_DEFAULT =
    (LOCKOUT_MS * OSC_HZ_DEFAULT + 999) / 1000;
  localparam int unsigned LOCK_CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] IO_FUNCTION_CONFIG_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] PORT1_PULLUP_ENABLE_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] PIN_MUX_STATUS_OFS = 12'h008;

  // Field positions
  localparam int unsigned CFG_RST_MUX_BIT = 5;
  localparam int unsigned CFG_SWD_MUX_BIT = 6;
  localparam int unsigned PUE_P18_BIT = 8;
  localparam int unsigned PUE_P19_BIT = 9;
  localparam int unsigned STS_SWD_MUXED_BIT = 0;
  localparam int unsigned STS_RST_MUXED_BIT = 1;
  localparam int unsigned STS_LOCK_DONE_BIT = 2;

  // Reset values
  localparam logic [31:0] IO_FUNCTION_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] PORT1_PULLUP_ENABLE_RST = 32'h0000_0000;
  // Writable bits of each register
  localparam logic [31:0] IO_FUNCTION_CONFIG_MASK = 32'h0000_0060;
  localparam logic [31:0] PORT1_PULLUP_ENABLE_MASK = 32'h0000_ffff;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Carrier types
  typedef struct packed {
    logic rst_mux;
    logic swd_mux;
  } io_cfg_s;

  // Drive request for one pin: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_s;

endpackage : pin_mux_pkg

// ---- lockout_timer.sv ----
// Power-on lockout timer counted on low-speed oscillator ticks.
// Assumes osc_tick is a one-cycle pulse synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module lockout_timer #(
  parameter int unsigned TICKS = pin_mux_pkg::LOCKOUT_TICKS_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_tick,
  output logic done
);
  import pin_mux_pkg::*;

  localparam logic [LOCK_CNT_W-1:0] LAST = LOCK_CNT_W'(TICKS - 1);

  logic [LOCK_CNT_W-1:0] count_reg;
  logic done_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Count oscillator ticks until the lockout has run out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end else if (osc_tick && !done_reg) begin
      if (count_reg == LAST) begin
        done_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  assign done = done_reg;

endmodule // lockout_timer
`default_nettype wire

// ---- debug_reset_pin_mux.sv ----
// Pin-function mux for the two serial-wire debug pins and the reset pin.
// Assumes an AXI4-Lite master, a debug engine, port logic and a reset
// generator around it; the pad ring resolves levels from the enables.
//
// Contract
// - In debug function the clock pin is only ever an input.
// - The data pin turns around on the engine's request, input otherwise.
// - Under debug muxing the clock pin is P1.8 and the data pin is P1.9.
// - After hard reset both pins debug; bit 6 set makes them GPIO.
// - In debug function both pull-ups stay on whatever software writes.
// - As GPIO the pull-ups follow pull-up enable bits 8 and 9.
// - The debug mux waits for the 30 ms lockout after power-on.
// - Once muxed the debug port offers no access, erase or download.
// - The reset pin resets by default; bit 5 set makes it P0.2.
// - In reset function execution waits for the pin's release.
// - With reset muxing only watchdog or power cause hard reset.
// - Reset muxing leaves the debug port fully usable.
`timescale 1ns/1ps
`default_nettype none
module debug_reset_pin_mux #(
  parameter int unsigned LOCKOUT_TICKS = pin_mux_pkg::LOCKOUT_TICKS_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [pin_mux_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Low-speed RC oscillator tick
  input wire logic low_speed_rc_oscillator,
  // Debug clock pin
  input wire logic swclk_pin_in,
  output logic swclk_pin_out,
  output logic swclk_pin_oe,
  output logic swclk_pullup_en,
  // Debug data pin
  input wire logic swdio_pin_in,
  output logic swdio_pin_out,
  output logic swdio_pin_oe,
  output logic swdio_pullup_en,
  // External reset pin
  input wire logic external_reset_pin_in,
  output logic external_reset_pin_out,
  output logic external_reset_pin_oe,
  // Debug engine side
  input wire pin_mux_pkg::pin_drive_s dbg_swdio_drive,
  output logic dbg_swclk,
  output logic dbg_swdio_in,
  output logic dbg_access_en,
  // Port logic side: P1.8, P1.9, P0.2
  input wire pin_mux_pkg::pin_drive_s p1_8_drive,
  input wire pin_mux_pkg::pin_drive_s p1_9_drive,
  input wire pin_mux_pkg::pin_drive_s p0_2_drive,
  output logic p1_8_in,
  output logic p1_9_in,
  output logic p0_2_in,
  // Reset generator side
  input wire logic watchdog_reset_req,
  output logic hard_reset_req,
  output logic exec_hold
);
  import pin_mux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] cfg_reg;
  logic [31:0] pue_reg;
  io_cfg_s eff_reg;
  logic lock_done;
  logic do_write;
  logic wr_hit_cfg;
  logic wr_hit_pue;
  logic [31:0] strb_mask;
  logic [31:0] status_word;
  logic swclk_out_reg, swclk_oe_reg, swclk_pu_reg;
  logic swdio_out_reg, swdio_oe_reg, swdio_pu_reg;
  logic rst_out_reg, rst_oe_reg;
  logic dbg_swclk_reg, dbg_swdio_in_reg, dbg_access_reg;
  logic p18_in_reg, p19_in_reg, p02_in_reg;
  logic hard_reset_reg, exec_hold_reg;

  // Address decode shared by the read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == IO_FUNCTION_CONFIG_OFS) ||
           (a == PORT1_PULLUP_ENABLE_OFS) ||
           (a == PIN_MUX_STATUS_OFS);
  endfunction

  // Expand byte strobes to a bit mask
  function automatic logic [31:0] expand_strb(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Power-on lockout
  // lockout timer
  lockout_timer #(
    .TICKS(LOCKOUT_TICKS)
  ) u_lockout (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_tick(low_speed_rc_oscillator),
    .done(lock_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit_cfg = do_write && (waddr_reg == IO_FUNCTION_CONFIG_OFS);
  assign wr_hit_pue = do_write && (waddr_reg == PORT1_PULLUP_ENABLE_OFS);
  assign strb_mask = expand_strb(wstrb_reg);

  // Capture the write address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      waddr_reg <= '0;
    end else if (awvalid && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      waddr_reg <= awaddr;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Capture the write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (wvalid && !w_held_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  // debug after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= IO_FUNCTION_CONFIG_RST;
    end else if (wr_hit_cfg) begin
      // Early writes are kept; the lockout gates bit 6 later
      cfg_reg <= (cfg_reg & ~(strb_mask & IO_FUNCTION_CONFIG_MASK)) |
                 (wdata_reg & strb_mask & IO_FUNCTION_CONFIG_MASK);
    end
  end

  // Port 1 pull-up enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pue_reg <= PORT1_PULLUP_ENABLE_RST;
    end else if (wr_hit_pue) begin
      pue_reg <= (pue_reg & ~(strb_mask & PORT1_PULLUP_ENABLE_MASK)) |
                 (wdata_reg & strb_mask & PORT1_PULLUP_ENABLE_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective pin functions
  // debug mux applies after lockout, reset mux at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eff_reg <= '0;
    end else begin
      eff_reg.swd_mux <= cfg_reg[CFG_SWD_MUX_BIT] && lock_done;
      eff_reg.rst_mux <= cfg_reg[CFG_RST_MUX_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always_comb begin
    status_word = '0;
    status_word[STS_SWD_MUXED_BIT] = eff_reg.swd_mux;
    status_word[STS_RST_MUXED_BIT] = eff_reg.rst_mux;
    status_word[STS_LOCK_DONE_BIT] = lock_done;
  end

  // Read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      case (araddr)
        IO_FUNCTION_CONFIG_OFS: rdata_reg <= cfg_reg;
        PORT1_PULLUP_ENABLE_OFS: rdata_reg <= pue_reg;
        PIN_MUX_STATUS_OFS: rdata_reg <= status_word;
        default: rdata_reg <= '0;
      endcase
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug clock pin / P1.8
  // clock not driven in debug function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swclk_out_reg <= 1'b0;
      swclk_oe_reg <= 1'b0;
    end else begin
      swclk_out_reg <= eff_reg.swd_mux & p1_8_drive.out;
      swclk_oe_reg <= eff_reg.swd_mux & p1_8_drive.oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug data pin / P1.9
  // data turnaround
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swdio_out_reg <= 1'b0;
      swdio_oe_reg <= 1'b0;
    end else if (eff_reg.swd_mux) begin
      swdio_out_reg <= p1_9_drive.out;
      swdio_oe_reg <= p1_9_drive.oe;
    end else begin
      swdio_out_reg <= dbg_swdio_drive.out;
      swdio_oe_reg <= dbg_swdio_drive.oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pull-ups of both debug pins
  // forced pull-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swclk_pu_reg <= 1'b1;
      swdio_pu_reg <= 1'b1;
    end else begin
      swclk_pu_reg <= !eff_reg.swd_mux || pue_reg[PUE_P18_BIT];
      swdio_pu_reg <= !eff_reg.swd_mux || pue_reg[PUE_P19_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inputs toward the debug engine and port logic
  // debug cut off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dbg_swclk_reg <= 1'b1;
      dbg_swdio_in_reg <= 1'b1;
      dbg_access_reg <= 1'b1;
      p18_in_reg <= 1'b0;
      p19_in_reg <= 1'b0;
    end else begin
      // Idle-high levels to the engine while muxed
      dbg_swclk_reg <= eff_reg.swd_mux ? 1'b1 : swclk_pin_in;
      dbg_swdio_in_reg <= eff_reg.swd_mux ? 1'b1 : swdio_pin_in;
      dbg_access_reg <= !eff_reg.swd_mux;
      p18_in_reg <= eff_reg.swd_mux & swclk_pin_in;
      p19_in_reg <= eff_reg.swd_mux & swdio_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin / P0.2
  // reset pin as P0.2
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_out_reg <= 1'b0;
      rst_oe_reg <= 1'b0;
      p02_in_reg <= 1'b0;
    end else begin
      rst_out_reg <= eff_reg.rst_mux & p0_2_drive.out;
      rst_oe_reg <= eff_reg.rst_mux & p0_2_drive.oe;
      p02_in_reg <= eff_reg.rst_mux & external_reset_pin_in;
    end
  end

  // Reset requests and execution hold
  // hold until release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hard_reset_reg <= 1'b0;
      exec_hold_reg <= 1'b1;
    end else begin
      hard_reset_reg <= watchdog_reset_req ||
                        (!eff_reg.rst_mux && !external_reset_pin_in);
      exec_hold_reg <= !eff_reg.rst_mux && !external_reset_pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output assignments, all from flip-flops
  assign awready = !aw_held_reg;
  assign wready = !w_held_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = !rvalid_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign swclk_pin_out = swclk_out_reg;
  assign swclk_pin_oe = swclk_oe_reg;
  assign swclk_pullup_en = swclk_pu_reg;
  assign swdio_pin_out = swdio_out_reg;
  assign swdio_pin_oe = swdio_oe_reg;
  assign swdio_pullup_en = swdio_pu_reg;
  assign external_reset_pin_out = rst_out_reg;
  assign external_reset_pin_oe = rst_oe_reg;
  assign dbg_swclk = dbg_swclk_reg;
  assign dbg_swdio_in = dbg_swdio_in_reg;
  assign dbg_access_en = dbg_access_reg;
  assign p1_8_in = p18_in_reg;
  assign p1_9_in = p19_in_reg;
  assign p0_2_in = p02_in_reg;
  assign hard_reset_req = hard_reset_reg;
  assign exec_hold = exec_hold_reg;

endmodule // debug_reset_pin_mux
`default_nettype wire

// ---- pin_mux_checker.sv ----
// Assertions on the pin side of the debug/reset pin mux.
// Assumes it is bound into debug_reset_pin_mux and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pin_mux_checker #(
  parameter int unsigned LOCKOUT_TICKS = pin_mux_pkg::LOCKOUT_TICKS_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_speed_rc_oscillator,
  input wire logic swclk_pin_in,
  input wire logic swclk_pin_oe,
  input wire logic swclk_pullup_en,
  input wire logic swdio_pin_in,
  input wire logic swdio_pin_oe,
  input wire logic swdio_pullup_en,
  input wire pin_mux_pkg::pin_drive_s dbg_swdio_drive,
  input wire logic dbg_swclk,
  input wire logic dbg_swdio_in,
  input wire logic dbg_access_en,
  input wire pin_mux_pkg::pin_drive_s p1_8_drive,
  input wire logic p1_8_in,
  input wire logic p1_9_in,
  input wire logic watchdog_reset_req,
  input wire logic hard_reset_req,
  input wire logic exec_hold
);
  import pin_mux_pkg::*;
  int unsigned tick_cnt;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////
  // Oscillator ticks since reset, saturating at 32'hffff, well above the default lockout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 0;
    end else if (low_speed_rc_oscillator && tick_cnt < 32'hffff) begin
      tick_cnt <= tick_cnt + 1;
    end
  end

  // Three settled cycles in one function, so switch-over edges are skipped
  sequence dbg_owned_s; dbg_access_en [*3]; endsequence
  sequence gpio_owned_s; !dbg_access_en [*3]; endsequence

  ////////////////////////////////////////
  clk_input_only_a: assert property (dbg_owned_s |-> !swclk_pin_oe)
    else $error("debug clock pin driven in debug function");
  dio_turnaround_a: assert property (
    dbg_owned_s |-> swdio_pin_oe == $past(dbg_swdio_drive.oe))
    else $error("data pin enable does not follow the engine");
  pullup_forced_a: assert property (
    dbg_owned_s |-> swclk_pullup_en && swdio_pullup_en)
    else $error("pull-up off in debug function");
  gpio_inputs_a: assert property (gpio_owned_s |->
    p1_8_in == $past(swclk_pin_in) && p1_9_in == $past(swdio_pin_in))
    else $error("port inputs do not follow the pins");
  gpio_drive_a: assert property (
    gpio_owned_s |-> swclk_pin_oe == $past(p1_8_drive.oe))
    else $error("clock pin enable does not follow the port");
  probe_cut_a: assert property (
    gpio_owned_s |-> dbg_swclk && dbg_swdio_in)
    else $error("engine still sees the pins while muxed");
  lockout_hold_a: assert property (
    !dbg_access_en |-> tick_cnt >= LOCKOUT_TICKS)
    else $error("debug pins switched before the lockout ended");
  hold_means_reset_a: assert property (
    $past(aresetn) && exec_hold |-> hard_reset_req)
    else $error("execution held without a reset request");
  watchdog_reset_a: assert property (
    $past(aresetn) && $past(watchdog_reset_req) |-> hard_reset_req)
    else $error("watchdog did not raise a hard reset");
endmodule // pin_mux_checker

bind debug_reset_pin_mux pin_mux_checker #(
  .LOCKOUT_TICKS(LOCKOUT_TICKS)
) checker_i (.*);
`default_nettype wire

// ---- probe_model.sv ----
// Debug probe and external reset circuit standing at the three pins.
// Assumes the bench sets its drive controls just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module probe_model (
  input wire logic aclk,
  input wire logic swclk_pin_out,
  input wire logic swclk_pin_oe,
  input wire logic swclk_pullup_en,
  input wire logic swdio_pin_out,
  input wire logic swdio_pin_oe,
  input wire logic swdio_pullup_en,
  input wire logic external_reset_pin_out,
  input wire logic external_reset_pin_oe,
  input wire logic clk_oe,
  input wire logic clk_lvl,
  input wire logic dio_oe,
  input wire logic dio_lvl,
  input wire logic rst_low,
  output logic swclk_pin_in,
  output logic swdio_pin_in,
  output logic external_reset_pin_in
);
  logic wobble = 1'b0;

  ////////////////////////////////////////
  // Changing level for a line that nobody drives or pulls
  always @(posedge aclk) begin
    wobble <= ~wobble;
  end

  assign swclk_pin_in = clk_oe ? clk_lvl : swclk_pin_oe ? swclk_pin_out :
    swclk_pullup_en ? 1'b1 : wobble;
  assign swdio_pin_in = dio_oe ? dio_lvl : swdio_pin_oe ? swdio_pin_out :
    swdio_pullup_en ? 1'b1 : wobble;
  assign external_reset_pin_in = rst_low ? 1'b0 :
    external_reset_pin_oe ? external_reset_pin_out : 1'b1;
endmodule // probe_model
`default_nettype wire

// ---- debug_reset_pin_mux_test.sv ----
// Self-checking bench for the debug/reset pin mux.
// Assumes the package, the design, probe_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module debug_reset_pin_mux_test;
  import pin_mux_pkg::*;
  localparam int unsigned LT = 4;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, low_speed_rc_oscillator;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic swclk_pin_in, swclk_pin_out, swclk_pin_oe, swclk_pullup_en;
  logic swdio_pin_in, swdio_pin_out, swdio_pin_oe, swdio_pullup_en;
  logic external_reset_pin_in, external_reset_pin_out, external_reset_pin_oe;
  pin_drive_s dbg_swdio_drive, p1_8_drive, p1_9_drive, p0_2_drive;
  logic dbg_swclk, dbg_swdio_in, dbg_access_en, p1_8_in, p1_9_in, p0_2_in;
  logic watchdog_reset_req, hard_reset_req, exec_hold;
  logic clk_oe, clk_lvl, dio_oe, dio_lvl, rst_low;
  int error_cnt = 0;
  int n_checks = 0;

  debug_reset_pin_mux #(.LOCKOUT_TICKS(LT)) DUT (.*);
  probe_model probe (.*);

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  ////////////////////////////////////////
  // Verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare a word, then a flag
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  // Bus write: address and data together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) chk("write wait", 32'h1, 32'h0);
    if (n >= 50) conclude();
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  // Bus read, data and response taken at the rvalid edge
  task automatic rd(input logic [11:0] a, input logic [31:0] ev,
    input logic [1:0] er, input string nm);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50) chk("read wait", 32'h1, 32'h0);
    if (n >= 50) conclude();
    chk(nm, ev, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // Let registered outputs land, then sample off the edge
  task automatic settle();
    repeat (4) @(posedge aclk);
    #1;
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge aclk);
      low_speed_rc_oscillator <= 1'b1;
      @(posedge aclk);
      low_speed_rc_oscillator <= 1'b0;
    end
  endtask

  ////////////////////////////////////////
  // Reset state, unmapped read and write, pin defaults
  task automatic t_reset();
    rd(IO_FUNCTION_CONFIG_OFS, 32'h0, RESP_OKAY, "cfg");
    rd(PORT1_PULLUP_ENABLE_OFS, 32'h0, RESP_OKAY, "pue");
    rd(PIN_MUX_STATUS_OFS, 32'h0, RESP_OKAY, "status");
    rd(12'h00c, 32'h0, RESP_SLVERR, "unmapped");
    wr(12'h00c, 32'hffff_ffff, RESP_SLVERR);
    chkb("clk oe", 1'b0, swclk_pin_oe);
    chkb("access", 1'b1, dbg_access_en);
    chkb("pullup", 1'b1, swdio_pullup_en);
  endtask

  // Early enable is stored but waits for the whole lockout
  task automatic t_lockout();
    wr(IO_FUNCTION_CONFIG_OFS, 32'hffff_ffdf, RESP_OKAY);
    rd(IO_FUNCTION_CONFIG_OFS, 32'h40, RESP_OKAY, "cfg bits");
    ticks(LT - 1);
    settle();
    chkb("access early", 1'b1, dbg_access_en);
    ticks(1);
    settle();
    chkb("access late", 1'b0, dbg_access_en);
    rd(PIN_MUX_STATUS_OFS, 32'h5, RESP_OKAY, "status muxed");
  endtask

  // Pins as port pins: pull-ups, drives, inputs, engine cut off
  task automatic t_gpio();
    wstrb <= 4'hd;
    wr(PORT1_PULLUP_ENABLE_OFS, 32'h0000_0300, RESP_OKAY);
    wstrb <= 4'hf;
    rd(PORT1_PULLUP_ENABLE_OFS, 32'h0, RESP_OKAY, "pue lanes");
    wr(PORT1_PULLUP_ENABLE_OFS, 32'h0000_0100, RESP_OKAY);
    @(posedge aclk);
    {p1_8_drive, p1_9_drive} <= 4'b1101;
    settle();
    chkb("clk pull", 1'b1, swclk_pullup_en);
    chkb("dio pull", 1'b0, swdio_pullup_en);
    chkb("clk oe", 1'b1, swclk_pin_oe);
    chkb("clk out", 1'b1, swclk_pin_out);
    chkb("dio out", 1'b0, swdio_pin_out);
    chkb("p1_9 in", 1'b0, p1_9_in);
    chkb("dbg clk", 1'b1, dbg_swclk);
    @(posedge aclk);
    {p1_8_drive, p1_9_drive, dbg_swdio_drive} <= 6'b000011;
    {clk_oe, clk_lvl} <= 2'b10;
    settle();
    chkb("p1_8 in", 1'b0, p1_8_in);
    chkb("dio oe", 1'b0, swdio_pin_oe);
    chkb("dbg dio", 1'b1, dbg_swdio_in);
  endtask

  // Firmware exit path back to debug function
  task automatic t_exit();
    wr(PORT1_PULLUP_ENABLE_OFS, 32'h0, RESP_OKAY);
    wr(IO_FUNCTION_CONFIG_OFS, 32'h0, RESP_OKAY);
    settle();
    chkb("access back", 1'b1, dbg_access_en);
    chkb("clk free", 1'b0, swclk_pin_oe);
    chkb("dio pull", 1'b1, swdio_pullup_en);
    chkb("dio drive", 1'b1, swdio_pin_oe);
    chkb("dio level", 1'b1, swdio_pin_out);
    chkb("dbg clk low", 1'b0, dbg_swclk);
    @(posedge aclk);
    dbg_swdio_drive <= 2'b00;
    {clk_oe, dio_oe, dio_lvl} <= 3'b010;
    settle();
    chkb("dio idle", 1'b0, swdio_pin_oe);
    chkb("dbg dio", 1'b0, dbg_swdio_in);
    chkb("clk pulled", 1'b1, dbg_swclk);
  endtask

  // Reset pin in both functions, watchdog, return
  task automatic t_rstpin();
    @(posedge aclk);
    {rst_low, dio_oe} <= 2'b10;
    settle();
    chkb("hold", 1'b1, exec_hold);
    chkb("pin reset", 1'b1, hard_reset_req);
    @(posedge aclk);
    rst_low <= 1'b0;
    settle();
    chkb("run", 1'b0, exec_hold);
    wr(IO_FUNCTION_CONFIG_OFS, 32'h20, RESP_OKAY);
    @(posedge aclk);
    rst_low <= 1'b1;
    settle();
    chkb("pin ignored", 1'b0, hard_reset_req);
    chkb("no hold", 1'b0, exec_hold);
    chkb("p0_2 in low", 1'b0, p0_2_in);
    @(posedge aclk);
    rst_low <= 1'b0;
    p0_2_drive <= 2'b11;
    settle();
    chkb("p0_2 oe", 1'b1, external_reset_pin_oe);
    chkb("p0_2 out", 1'b1, external_reset_pin_out);
    chkb("p0_2 in", 1'b1, p0_2_in);
    chkb("debug kept", 1'b1, dbg_access_en);
    rd(PIN_MUX_STATUS_OFS, 32'h6, RESP_OKAY, "status rst");
    @(posedge aclk);
    watchdog_reset_req <= 1'b1;
    settle();
    chkb("watchdog", 1'b1, hard_reset_req);
    @(posedge aclk);
    watchdog_reset_req <= 1'b0;
    p0_2_drive <= 2'b00;
    rst_low <= 1'b1;
    wr(IO_FUNCTION_CONFIG_OFS, 32'h0, RESP_OKAY);
    settle();
    chkb("pin reset back", 1'b1, hard_reset_req);
  endtask

  // Mid-run reset drops the enable and restarts the lockout
  task automatic t_rerst();
    wr(IO_FUNCTION_CONFIG_OFS, 32'h40, RESP_OKAY);
    settle();
    chkb("access off", 1'b0, dbg_access_en);
    @(posedge aclk);
    {aresetn, rst_low} <= 2'b00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chkb("access rst", 1'b1, dbg_access_en);
    rd(PIN_MUX_STATUS_OFS, 32'h0, RESP_OKAY, "status relock");
    rd(IO_FUNCTION_CONFIG_OFS, 32'h0, RESP_OKAY, "cfg relock");
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wdata} = '0;
    {low_speed_rc_oscillator, watchdog_reset_req} = '0;
    {dbg_swdio_drive, p1_8_drive, p1_9_drive, p0_2_drive} = '0;
    {clk_oe, clk_lvl, dio_oe, dio_lvl, rst_low} = '0;
    wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    // margin waived: early write exercises the lockout
    t_lockout();
    t_gpio();
    t_exit();
    t_rstpin();
    t_rerst();
    conclude();
  end
endmodule // debug_reset_pin_mux_test
`default_nettype wire
